// [inc/fpc_pkg.sv]
// flash protection controller: constants, types and register map
// assumes a 32-bit axi4-lite register bus and a 10 mhz system clock
package fpc_pkg;

	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [11:0] FPC_ADDR_OFS = 12'h000;
	localparam logic [11:0] FPC_DATA_OFS = 12'h004;
	localparam logic [11:0] FPC_CTRL_OFS = 12'h008;
	localparam logic [11:0] FPC_RIS_OFS = 12'h00c;
	localparam logic [11:0] FPC_MASK_OFS = 12'h010;
	localparam logic [11:0] FPC_MISC_OFS = 12'h014;
	localparam logic [11:0] FPC_RDMEM_OFS = 12'h018;
	localparam logic [11:0] FPC_STAT_OFS = 12'h01c;
	localparam logic [11:0] FPC_RE_OFS = 12'h130;
	localparam logic [11:0] FPC_PE_OFS = 12'h134;
	localparam logic [11:0] FPC_USEC_OFS = 12'h140;

	// ------------------------------------------------------------
	// fields and reset values
	// ------------------------------------------------------------
	localparam logic [15:0] FPC_WR_KEY = 16'ha442;
	localparam int FPC_CTL_WRITE = 0;
	localparam int FPC_CTL_ERASE = 1;
	localparam int FPC_CTL_MERASE = 2;
	localparam int FPC_CTL_COMMIT = 3;
	localparam int FPC_IRQ_ACCESS = 0;
	localparam int FPC_IRQ_PROG = 1;
	localparam int FPC_DBG_LSB = 30;
	localparam logic [1:0] FPC_DBG_ON = 2'h2;
	localparam logic [31:0] FPC_RE_RST = 32'hbfff_ffff;
	localparam logic [31:0] FPC_PE_RST = 32'hffff_ffff;
	localparam logic [7:0] FPC_USEC_RST = 8'h31;
	localparam logic [15:0] FPC_DBG_COMMIT_ADDR = 16'h0900;
	localparam logic [1:0] FPC_RESP_OKAY = 2'b00;
	localparam logic [1:0] FPC_RESP_SLVERR = 2'b10;

	// ------------------------------------------------------------
	// timing: pulse lengths in microseconds
	// ------------------------------------------------------------
	localparam int FPC_PROG_US = 20;
	localparam int FPC_ERASE_US = 100;
	localparam int FPC_COMMIT_US = 20;

	typedef enum logic [3:0] {
		FPC_IDLE = 4'b0001,
		FPC_BUSY = 4'b0010,
		FPC_FILL = 4'b0100,
		FPC_DONE = 4'b1000
	} fpc_state_t;

	typedef struct packed {
		logic [15:0] key;
		logic [11:0] rsvd;
		logic commit;
		logic merase;
		logic erase;
		logic write;
	} fpc_ctrl_t;

	typedef struct packed {
		logic prog_done;
		logic access_viol;
	} fpc_irq_t;

endpackage : fpc_pkg

// [logic/fpc_top.sv]
// flash protection controller: array, protection, timing and events
// assumes an axi4-lite master on aclk; the array is modelled in-block
//
// Contract
// - array erases in 1 kb blocks; erase sets every bit to one
// - word program only clears bits, never sets a zero to one
// - protection per 2 kb unit, one program and one read bit each
// - program-enable zero forbids program and erase of the unit
// - read-enable zero refuses data reads; fetch and, if program-enabled, program and erase stay
// - execute-only unit serves fetch only, refuses data reads and writes
// - bit pair decodes execute-only, write-only, read-only, open
// - data read of read-protected unit returns a bus fault
// - program or erase on protected unit flags access event, masked irq
// - protection bits start open except the read bit of unit 30, which is zero in debug field 0x2; debug access starts open
// - software only clears protection bits; uncommitted revert on reset
// - commit makes the selected protection set permanent; read bits 31:30 only via 0x900
// - program or erase completion sets the done event
// - raw status always visible; masked status and irq gated by mask
// - write one to masked-clear register clears the event
// - debug field 0x2 enables debug port, cleared disables it
// - committed debug clear is permanent, effective next power-up
// - debug disable leaves the test access port working
// - address bit 0 picks program or read set for commit
// - address 0x900 commits the debug field with read set
// - keyed control write starts op; bit clears when done
`timescale 1ns/10ps
module fpc_top #(
	parameter int WORDS = 16384,
	parameter int UNITS = 32,
	parameter int CLK_MHZ = 10
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	input wire logic [11:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready,
	input wire logic fetch_req,
	input wire logic [15:0] fetch_addr,
	output logic [31:0] fetch_data,
	output logic fetch_valid,
	output logic flash_irq,
	output logic debug_port_enable,
	output logic tap_enable
);
	import fpc_pkg::*;

	localparam int AW = $clog2(WORDS);
	// words per 1 kb block, and log2 of words per 2 kb unit
	localparam int BLK_W = 256;
	localparam int UNIT_SH = 9;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic [31:0] mem [WORDS];
	logic [15:0] addr_r;
	logic [31:0] data_r;
	logic [3:0] op_r;
	logic [31:0] re_r, pe_r;
	// committed image: nonvolatile, holds the delivered value from power-up
	logic [31:0] re_com_r = FPC_RE_RST;
	logic [31:0] pe_com_r = FPC_PE_RST;
	logic [1:0] dbg_boot_r;
	logic [7:0] usec_r;
	fpc_irq_t ris_r, mask_r;
	fpc_state_t st_r;
	logic [7:0] us_cnt_r;
	logic [7:0] pulse_r;
	logic [AW-1:0] fill_r, fill_end_r;
	logic [31:0] rdmem_r;

	// ------------------------------------------------------------
	// decode helpers
	// ------------------------------------------------------------
	function automatic logic [4:0] unit_of(input logic [15:0] a);
		unit_of = a[UNIT_SH+6:UNIT_SH+2];
	endfunction : unit_of

	// program/read pair gives the access rights of a unit
	function automatic logic can_write(input logic [4:0] u,
			input logic [31:0] pe);
		can_write = pe[u];
	endfunction : can_write

	function automatic logic can_read(input logic [4:0] u,
			input logic [31:0] re);
		can_read = re[u];
	endfunction : can_read

	// ------------------------------------------------------------
	// axi4-lite write channel
	// ------------------------------------------------------------
	logic aw_hold_r, w_hold_r;
	logic [11:0] awaddr_r;
	logic [31:0] wdata_r;
	logic do_wr;
	fpc_ctrl_t ctl;

	assign do_wr = aw_hold_r && w_hold_r && !s_bvalid;
	assign ctl = fpc_ctrl_t'(wdata_r);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			awaddr_r <= 12'h000;
			wdata_r <= 32'h0000_0000;
			s_awready <= 1'b0;
			s_wready <= 1'b0;
			s_bvalid <= 1'b0;
			s_bresp <= FPC_RESP_OKAY;
		end else begin
			s_awready <= !aw_hold_r && !s_awready && !s_bvalid;
			s_wready <= !w_hold_r && !s_wready && !s_bvalid;
			if (s_awvalid && s_awready) begin
				aw_hold_r <= 1'b1;
				awaddr_r <= s_awaddr;
				s_awready <= 1'b0;
			end
			if (s_wvalid && s_wready) begin
				w_hold_r <= 1'b1;
				wdata_r <= s_wdata;
				s_wready <= 1'b0;
			end
			if (do_wr) begin
				aw_hold_r <= 1'b0;
				w_hold_r <= 1'b0;
				s_bvalid <= 1'b1;
				s_bresp <= FPC_RESP_OKAY;
			end
			if (s_bvalid && s_bready)
				s_bvalid <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// plain registers
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			addr_r <= 16'h0000;
			data_r <= 32'h0000_0000;
			usec_r <= FPC_USEC_RST;
			mask_r <= '0;
		end else if (do_wr) begin
			unique case (awaddr_r)
				FPC_ADDR_OFS: addr_r <= wdata_r[15:0];
				FPC_DATA_OFS: data_r <= wdata_r;
				FPC_MASK_OFS: mask_r <= fpc_irq_t'(wdata_r[1:0]);
				FPC_USEC_OFS: usec_r <= wdata_r[7:0];
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------
	// protection bits: working copy and committed image
	// ------------------------------------------------------------
	// the committed image models nonvolatile storage: no reset touches
	// it, so only a commit changes it; aresetn stands in for power-on.
	logic commit_go;
	always_ff @(posedge aclk) begin
		if (commit_go) begin
			if (addr_r[0])
				pe_com_r <= pe_com_r & pe_r;
			else if (addr_r == FPC_DBG_COMMIT_ADDR)
				re_com_r <= re_com_r & re_r;
			else
				re_com_r <= {re_com_r[31:30],
					re_com_r[29:0] & re_r[29:0]};
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			// uncommitted clears revert to the committed image
			re_r <= re_com_r;
			pe_r <= pe_com_r;
			dbg_boot_r <= re_com_r[FPC_DBG_LSB +: 2];
		end else if (do_wr && awaddr_r == FPC_RE_OFS) begin
			re_r <= re_r & wdata_r;
		end else if (do_wr && awaddr_r == FPC_PE_OFS) begin
			pe_r <= pe_r & wdata_r;
		end
	end

	// debug field sampled at power-up only; test access port untouched
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			debug_port_enable <= 1'b0;
			tap_enable <= 1'b0;
		end else begin
			debug_port_enable <= (dbg_boot_r == FPC_DBG_ON);
			tap_enable <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// operation sequencer
	// ------------------------------------------------------------
	logic key_ok, op_write, us_tick;
	logic [4:0] op_unit;
	assign key_ok = do_wr && awaddr_r == FPC_CTRL_OFS && ctl.key == FPC_WR_KEY
		&& st_r == FPC_IDLE;
	assign op_write = ctl.write || ctl.erase || ctl.merase;
	assign op_unit = unit_of(addr_r);
	assign us_tick = (us_cnt_r == 8'h00);
	assign commit_go = key_ok && ctl.commit;

	logic blocked;
	// mass erase is refused while any unit is program-protected
	assign blocked = ctl.merase ? (pe_r != 32'hffff_ffff)
		: !can_write(op_unit, pe_r);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= FPC_IDLE;
			op_r <= 4'h0;
			us_cnt_r <= 8'h00;
			pulse_r <= 8'h00;
			fill_r <= '0;
			fill_end_r <= '0;
		end else begin
			us_cnt_r <= us_tick ? usec_r : us_cnt_r - 8'h01;
			unique case (st_r)
				FPC_IDLE: begin
					if (key_ok && op_write && !blocked) begin
						op_r <= ctl[3:0];
						st_r <= FPC_BUSY;
						us_cnt_r <= usec_r;
						pulse_r <= ctl.write ? 8'(FPC_PROG_US)
							: 8'(FPC_ERASE_US);
					end else if (commit_go) begin
						op_r <= ctl[3:0];
						st_r <= FPC_BUSY;
						us_cnt_r <= usec_r;
						pulse_r <= 8'(FPC_COMMIT_US);
					end
				end
				FPC_BUSY: begin
					if (us_tick) begin
						if (pulse_r == 8'h01) begin
							st_r <= op_r[FPC_CTL_ERASE] || op_r[FPC_CTL_MERASE]
								? FPC_FILL : FPC_DONE;
							fill_r <= op_r[FPC_CTL_MERASE] ? '0
								: (AW'(addr_r >> 2) & ~AW'(BLK_W - 1));
							fill_end_r <= op_r[FPC_CTL_MERASE] ? AW'(WORDS - 1)
								: (AW'(addr_r >> 2) | AW'(BLK_W - 1));
						end
						pulse_r <= pulse_r - 8'h01;
					end
				end
				FPC_FILL: begin
					fill_r <= fill_r + AW'(1);
					if (fill_r == fill_end_r)
						st_r <= FPC_DONE;
				end
				FPC_DONE: begin
					op_r <= 4'h0;
					st_r <= FPC_IDLE;
				end
				default: st_r <= FPC_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// array
	// ------------------------------------------------------------
	logic [AW-1:0] widx;
	assign widx = AW'(addr_r >> 2);

	always_ff @(posedge aclk) begin
		if (st_r == FPC_FILL)
			mem[fill_r] <= 32'hffff_ffff;
		else if (st_r == FPC_BUSY && us_tick && pulse_r == 8'h01
				&& op_r[FPC_CTL_WRITE])
			mem[widx] <= mem[widx] & data_r;
	end

	// fetch path ignores read enables: execute stays allowed
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fetch_valid <= 1'b0;
			fetch_data <= 32'h0000_0000;
		end else begin
			fetch_valid <= fetch_req && st_r == FPC_IDLE;
			fetch_data <= mem[AW'(fetch_addr >> 2)];
		end
	end

	// ------------------------------------------------------------
	// events
	// ------------------------------------------------------------
	logic ev_acc, ev_prog;
	fpc_irq_t clr;
	assign ev_acc = key_ok && op_write && blocked;
	assign ev_prog = st_r == FPC_DONE && !op_r[FPC_CTL_COMMIT];
	assign clr = (do_wr && awaddr_r == FPC_MISC_OFS)
		? fpc_irq_t'(wdata_r[1:0]) : '0;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ris_r <= '0;
			flash_irq <= 1'b0;
		end else begin
			// a new event wins over a clear in the same cycle
			ris_r.access_viol <= ev_acc
				|| (ris_r.access_viol && !clr.access_viol);
			ris_r.prog_done <= ev_prog
				|| (ris_r.prog_done && !clr.prog_done);
			flash_irq <= |(ris_r & mask_r);
		end
	end

	// ------------------------------------------------------------
	// axi4-lite read channel
	// ------------------------------------------------------------
	logic [31:0] rd_val;
	logic rd_err;
	logic [4:0] rd_unit;
	assign rd_unit = unit_of(addr_r);

	always_comb begin
		rd_val = 32'h0000_0000;
		rd_err = 1'b0;
		unique case (s_araddr)
			FPC_ADDR_OFS: rd_val = {16'h0000, addr_r};
			FPC_DATA_OFS: rd_val = data_r;
			FPC_CTRL_OFS: rd_val = {28'h0000000, op_r};
			FPC_RIS_OFS: rd_val = {30'h0, ris_r};
			FPC_MASK_OFS: rd_val = {30'h0, mask_r};
			FPC_MISC_OFS: rd_val = {30'h0, ris_r & mask_r};
			FPC_RDMEM_OFS: begin
				rd_val = mem[widx];
				rd_err = !can_read(rd_unit, re_r);
			end
			FPC_STAT_OFS: rd_val = {28'h0000000, st_r};
			FPC_RE_OFS: rd_val = re_r;
			FPC_PE_OFS: rd_val = pe_r;
			FPC_USEC_OFS: rd_val = {24'h000000, usec_r};
			default: rd_err = 1'b1;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_arready <= 1'b0;
			s_rvalid <= 1'b0;
			s_rdata <= 32'h0000_0000;
			s_rresp <= FPC_RESP_OKAY;
		end else begin
			s_arready <= !s_rvalid && !s_arready;
			if (s_arvalid && s_arready) begin
				s_arready <= 1'b0;
				s_rvalid <= 1'b1;
				s_rdata <= rd_err ? 32'h0000_0000 : rd_val;
				s_rresp <= rd_err ? FPC_RESP_SLVERR : FPC_RESP_OKAY;
			end else if (s_rvalid && s_rready) begin
				s_rvalid <= 1'b0;
			end
		end
	end

endmodule : fpc_top

// [sim/fpc_bus_master.sv]
// axi4-lite master standing in for software on the system bus
// assumes a slave on aclk; every wait is bounded and flags hang
`timescale 1ns/10ps
module fpc_bus_master (
	input wire logic aclk,
	output logic [11:0] awaddr,
	output logic awvalid,
	input wire logic awready,
	output logic [31:0] wdata,
	output logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	output logic bready,
	output logic [11:0] araddr,
	output logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	output logic rready,
	output logic hang
);
	// ------------------------------
	// transfers
	// ------------------------------
	initial begin
		{awaddr, awvalid, wdata, wvalid, bready, hang} = '0;
		{araddr, arvalid, rready} = '0;
	end
	// address and data go out together, each dropped once taken
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge aclk);
		{awaddr, wdata} <= {a, d};
		{awvalid, wvalid, bready} <= 3'h7;
		for (n = 0; n < 60; n++) begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		bready <= 1'b0;
		if (n == 60) hang <= 1'b1;
	endtask : wr
	task automatic rd(input logic [11:0] a, output logic [31:0] d,
			output logic [1:0] r);
		int n;
		@(posedge aclk);
		araddr <= a;
		{arvalid, rready} <= 2'h3;
		for (n = 0; n < 60; n++) begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		{d, r} = {rdata, rresp};
		rready <= 1'b0;
		if (n == 60) hang <= 1'b1;
	endtask : rd
endmodule : fpc_bus_master

// [sim/fpc_top_props.sv]
// assertions on the controller's bus, fetch and debug ports
// assumes binding into fpc_top; sees only its ports
`timescale 1ns/10ps
module fpc_top_props
	import fpc_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_awvalid,
	input wire logic s_awready,
	input wire logic s_wvalid,
	input wire logic s_wready,
	input wire logic [1:0] s_bresp,
	input wire logic s_bvalid,
	input wire logic s_bready,
	input wire logic s_arvalid,
	input wire logic s_arready,
	input wire logic [31:0] s_rdata,
	input wire logic [1:0] s_rresp,
	input wire logic s_rvalid,
	input wire logic s_rready,
	input wire logic fetch_req,
	input wire logic fetch_valid,
	input wire logic debug_port_enable,
	input wire logic tap_enable
);
	// ------------------------------
	// properties
	// ------------------------------
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	property p_tap;
		aresetn && $past(aresetn) |-> tap_enable;
	endproperty
	a_tap: assert property (p_tap) else $error("test port off");
	property p_fetch;
		fetch_valid |-> $past(fetch_req);
	endproperty
	a_fetch: assert property (p_fetch) else $error("stray fetch");
	property p_wlat;
		s_awvalid && s_awready && s_wvalid && s_wready |-> ##[1:2] s_bvalid;
	endproperty
	a_wlat: assert property (p_wlat) else $error("late bvalid");
	property p_rlat;
		s_arvalid && s_arready |=> s_rvalid;
	endproperty
	a_rlat: assert property (p_rlat) else $error("late rvalid");
	property p_bdone;
		s_bvalid && s_bready |=> !s_bvalid;
	endproperty
	a_bdone: assert property (p_bdone) else $error("bvalid stuck");
	property p_rdone;
		s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata);
	endproperty
	a_rdone: assert property (p_rdone) else $error("rdata moved");
	// refused program or erase shows as an event, never a bus error
	property p_bok;
		s_bvalid |-> s_bresp == FPC_RESP_OKAY;
	endproperty
	a_bok: assert property (p_bok) else $error("write error");
	// the debug port only follows the committed field at reset
	property p_dbg;
		aresetn && $past(aresetn) && $past(aresetn, 2)
			|-> $stable(debug_port_enable);
	endproperty
	a_dbg: assert property (p_dbg) else $error("debug moved");
	c_fetch: cover property (fetch_valid);
	c_fault: cover property (s_rvalid && s_rresp == FPC_RESP_SLVERR);
	c_nodbg: cover property (!debug_port_enable);
endmodule : fpc_top_props
bind fpc_top fpc_top_props u_props (.aclk, .aresetn, .s_awvalid,
	.s_awready, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready,
	.s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready,
	.fetch_req, .fetch_valid, .debug_port_enable, .tap_enable);

// [sim/fpc_top_tb.sv]
// self-checking bench for the flash protection controller
// assumes fpc_top with its bound checker and fpc_bus_master as software
`timescale 1ns/10ps
module fpc_top_tb;
	import fpc_pkg::*;
	logic aclk, aresetn, fetch_req, fetch_valid, flash_irq, hang;
	logic debug_port_enable, tap_enable;
	logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
	logic s_arvalid, s_arready, s_rvalid, s_rready;
	logic [1:0] s_bresp, s_rresp, r;
	logic [11:0] s_awaddr, s_araddr;
	logic [15:0] fetch_addr;
	logic [31:0] s_wdata, s_rdata, fetch_data, v, a, d1, d2, seed;
	int miscompares, checks;
	// ------------------------------
	// design, software model, clock
	// ------------------------------
	fpc_top u_fpc_top (.aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready,
		.s_wdata, .s_wstrb(4'hf), .s_wvalid, .s_wready, .s_bresp, .s_bvalid,
		.s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp,
		.s_rvalid, .s_rready, .fetch_req, .fetch_addr, .fetch_data,
		.fetch_valid, .flash_irq, .debug_port_enable, .tap_enable);
	fpc_bus_master m_bus (.aclk, .awaddr(s_awaddr), .awvalid(s_awvalid),
		.awready(s_awready), .wdata(s_wdata), .wvalid(s_wvalid),
		.wready(s_wready), .bvalid(s_bvalid), .bready(s_bready),
		.araddr(s_araddr), .arvalid(s_arvalid), .arready(s_arready),
		.rdata(s_rdata), .rresp(s_rresp), .rvalid(s_rvalid),
		.rready(s_rready), .hang);
	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end
	// ------------------------------
	// helpers
	// ------------------------------
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	function automatic logic [31:0] ctl(input int b);
		return {FPC_WR_KEY, 16'h0} | (32'h1 << b);
	endfunction : ctl
	task automatic chk(input logic [33:0] got, input logic [33:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic give_verdict();
		if (miscompares == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : give_verdict
	task automatic rg(input logic [11:0] ad, input logic [31:0] exp);
		m_bus.rd(ad, v, r);
		chk({r, v}, {FPC_RESP_OKAY, exp});
	endtask : rg
	task automatic mem(input logic [31:0] ad, input logic [33:0] exp);
		m_bus.wr(FPC_ADDR_OFS, ad);
		m_bus.rd(FPC_RDMEM_OFS, v, r);
		chk({r, v}, exp);
	endtask : mem
	// start one operation, then poll until its bit clears
	task automatic op(input logic [31:0] ad, input logic [31:0] d,
			input int b);
		int n;
		m_bus.wr(FPC_ADDR_OFS, ad);
		m_bus.wr(FPC_DATA_OFS, d);
		m_bus.wr(FPC_CTRL_OFS, ctl(b));
		for (n = 0; n < 300; n++) begin
			m_bus.rd(FPC_CTRL_OFS, v, r);
			if (v[3:0] === 4'h0) break;
		end
		if (n == 300) begin
			miscompares++;
			give_verdict();
		end
	endtask : op
	// two edges after release so registered outputs have settled
	task automatic rst();
		aresetn <= 1'b0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
	endtask : rst
	always @(posedge aclk) begin
		if (hang === 1'b1) begin
			miscompares++;
			give_verdict();
		end
	end
	// ------------------------------
	// scenarios
	// ------------------------------
	initial begin
		int n;
		{fetch_req, fetch_addr, miscompares, checks} = '0;
		aresetn = 1'b0;
		seed = 32'd28417;
		rst();
		rg(FPC_RE_OFS, FPC_RE_RST);
		rg(FPC_PE_OFS, 32'hffff_ffff);
		rg(FPC_USEC_OFS, 32'h31);
		chk({33'h0, debug_port_enable}, 34'h1);
		m_bus.rd(12'h0f0, v, r);
		chk({r, v}, {FPC_RESP_SLVERR, 32'h0});
		m_bus.wr(FPC_USEC_OFS, 32'h0);
		rg(FPC_USEC_OFS, 32'h0);
		for (int i = 0; i < 3; i++) begin
			v = xs();
			a = {22'h0, v[7:0], 2'h0};
			op(32'h0, 32'h0, FPC_CTL_ERASE);
			mem(a, {FPC_RESP_OKAY, 32'hffff_ffff});
			d1 = xs();
			d2 = xs();
			op(a, d1, FPC_CTL_WRITE);
			op(a, d2, FPC_CTL_WRITE);
			mem(a, {FPC_RESP_OKAY, d1 & d2});
		end
		rg(FPC_RIS_OFS, 32'h2);
		rg(FPC_MISC_OFS, 32'h0);
		chk({33'h0, flash_irq}, 34'h0);
		m_bus.wr(FPC_MISC_OFS, 32'h0);
		rg(FPC_RIS_OFS, 32'h2);
		m_bus.wr(FPC_MASK_OFS, 32'h2);
		rg(FPC_MISC_OFS, 32'h2);
		chk({33'h0, flash_irq}, 34'h1);
		m_bus.wr(FPC_MISC_OFS, 32'h2);
		rg(FPC_RIS_OFS, 32'h0);
		op(32'h800, 32'h0, FPC_CTL_ERASE);
		m_bus.wr(FPC_RIS_OFS - 12'h0, 32'h0);
		m_bus.wr(FPC_MISC_OFS, 32'h2);
		m_bus.wr(FPC_PE_OFS, 32'hffff_fffd);
		m_bus.wr(FPC_PE_OFS, 32'hffff_ffff);
		rg(FPC_PE_OFS, 32'hffff_fffd);
		op(32'h804, xs(), FPC_CTL_WRITE);
		mem(32'h804, {FPC_RESP_OKAY, 32'hffff_ffff});
		rg(FPC_RIS_OFS, 32'h1);
		chk({33'h0, flash_irq}, 34'h0);
		m_bus.wr(FPC_MASK_OFS, 32'h1);
		rg(FPC_MISC_OFS, 32'h1);
		chk({33'h0, flash_irq}, 34'h1);
		m_bus.wr(FPC_MISC_OFS, 32'h1);
		op(32'h1000, 32'h0, FPC_CTL_ERASE);
		m_bus.wr(FPC_RE_OFS, 32'hffff_fffb);
		d1 = xs();
		op(32'h1000, d1, FPC_CTL_WRITE);
		rg(FPC_RIS_OFS, 32'h2);
		m_bus.wr(FPC_ADDR_OFS, 32'h1000);
		m_bus.rd(FPC_RDMEM_OFS, v, r);
		chk({32'h0, r}, {32'h0, FPC_RESP_SLVERR});
		fetch_addr <= 16'h1000;
		fetch_req <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge aclk);
			if (fetch_valid === 1'b1) break;
		end
		fetch_req <= 1'b0;
		chk({2'h0, fetch_data}, {2'h0, d1});
		if (n == 20) begin
			miscompares++;
			give_verdict();
		end
		op(32'h1, 32'h0, FPC_CTL_COMMIT);
		rst();
		rg(FPC_PE_OFS, 32'hffff_fffd);
		rg(FPC_RE_OFS, FPC_RE_RST);
		m_bus.wr(FPC_USEC_OFS, 32'h0);
		op(32'h800, 32'h0, FPC_CTL_ERASE);
		rg(FPC_RIS_OFS, 32'h1);
		m_bus.wr(FPC_MISC_OFS, 32'h1);
		op(32'h0, 32'h0, FPC_CTL_MERASE);
		rg(FPC_RIS_OFS, 32'h1);
		m_bus.wr(FPC_RE_OFS, 32'h3fff_fffb);
		op({16'h0, FPC_DBG_COMMIT_ADDR}, 32'h0, FPC_CTL_COMMIT);
		chk({33'h0, debug_port_enable}, 34'h1);
		rst();
		chk({33'h0, debug_port_enable}, 34'h0);
		chk({33'h0, tap_enable}, 34'h1);
		m_bus.wr(FPC_RE_OFS, 32'hffff_ffff);
		rg(FPC_RE_OFS, 32'h3fff_fffb);
		give_verdict();
	end
endmodule : fpc_top_tb
